// [hdl/level_control.sv]
/*
  ADC digital volume and automatic level control.
  Samples pass a FIFO, are scaled by the volume code and leave on a
  valid/ready stream; a peak detector steers the analogue PGA gain.
  Assumes samples arrive on CLK from the decimator, two's complement.
*/
`timescale 1ns/1ps
module level_control
  import level_ctl_pkg::*;
#(
  parameter int SAMPLE_W   = 16,
  parameter int FIFO_DEPTH = 16,
  parameter int FALL_NORM  = FALL_NORM_CYC,
  parameter int FALL_LIM   = FALL_LIM_CYC,
  parameter int RISE_NORM  = RISE_NORM_CYC,
  parameter int RISE_LIM   = RISE_LIM_CYC,
  parameter int HOLD_BASE  = HOLD_BASE_CYC
) (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RSTN,
  // Control port
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire logic [6:0]          REG_ADDR,
  input  wire logic [8:0]          REG_WDATA,
  output      logic [8:0]          REG_RDATA,
  // Samples from the decimator
  input  wire logic                IN_VALID,
  output      logic                IN_READY,
  input  wire logic [SAMPLE_W-1:0] IN_DATA,
  // Scaled samples out
  output      logic                OUT_VALID,
  input  wire logic                OUT_READY,
  output      logic [SAMPLE_W-1:0] OUT_DATA,
  // Analogue PGA gain code
  output      logic [PGA_W-1:0]    PGA_GAIN
);

  // ==========================================================
  // Declarations
  ctrl_t                ctl;
  lvl_state_t           state;
  logic                 f_valid;
  logic                 f_ready;
  logic [SAMPLE_W-1:0]  f_data;
  logic                 take;
  logic [7:0]           att;
  logic [3:0]           att_idx;
  logic [7:0]           att_sh;
  logic [SAMPLE_W+16:0] prod;
  logic [SAMPLE_W+16:0] scaled;
  logic [SAMPLE_W-1:0]  mag;
  logic [15:0]          mag_top;
  logic [15:0]          peak;
  logic [3:0]           tcode;
  logic [5:0]           tatt;
  logic [15:0]          thr;
  logic                 over_now;
  logic                 above;
  logic [PGA_W-1:0]     floor_idx;
  logic [PGA_W-1:0]     ceil_idx;
  logic [TIMER_W-1:0]   fall_len;
  logic [TIMER_W-1:0]   rise_len;
  logic [TIMER_W-1:0]   hold_len;
  logic [TIMER_W-1:0]   fall_cnt;
  logic [TIMER_W-1:0]   rise_cnt;
  logic [TIMER_W-1:0]   hold_cnt;
  logic                 fall_tick;
  logic                 rise_tick;
  logic                 hold_done;

  // Rate codes of ten and above all act as ten
  function automatic logic [3:0] rate_clip(input logic [3:0] code);
    rate_clip = (code > RATE_CODE_MAX) ? RATE_CODE_MAX : code;
  endfunction

  // ==========================================================
  // Register writes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl <= CTRL_RST;
    end else if (REG_WR) begin
      case (REG_ADDR)
        ADDR_GAIN: begin
          ctl.gain <= REG_WDATA[7:0];
        end
        ADDR_LC1: begin
          ctl.on      <= REG_WDATA[ON_BIT];
          ctl.ceiling <= REG_WDATA[CEIL_LSB +: 3];
          ctl.floor   <= REG_WDATA[FLOOR_LSB +: 3];
        end
        ADDR_LC2: begin
          ctl.hold   <= REG_WDATA[HOLD_LSB +: 4];
          ctl.target <= REG_WDATA[TARGET_LSB +: 4];
        end
        ADDR_LC3: begin
          ctl.style <= REG_WDATA[STYLE_BIT];
          ctl.rise  <= REG_WDATA[RISE_LSB +: 4];
          ctl.fall  <= REG_WDATA[FALL_LSB +: 4];
        end
        default: begin
        end
      endcase
    end
  end

  // Readback, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        ADDR_GAIN: REG_RDATA <= {1'b0, ctl.gain};
        ADDR_LC1:  REG_RDATA <= {ctl.on, 2'b00, ctl.ceiling, ctl.floor};
        ADDR_LC2:  REG_RDATA <= {1'b0, ctl.hold, ctl.target};
        ADDR_LC3:  REG_RDATA <= {ctl.style, ctl.rise, ctl.fall};
        default:   REG_RDATA <= '0;
      endcase
    end
  end

  // ==========================================================
  // Sample buffer; a stalled output backs up into IN_READY
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rstn      (RSTN),
    .in_valid  (IN_VALID),
    .in_ready  (IN_READY),
    .in_data   (IN_DATA),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign f_ready = !OUT_VALID || OUT_READY;
  assign take    = f_valid && f_ready;

  // ==========================================================
  // Volume: table gives the fraction, whole 6 dB steps are shifts
  assign att     = ATT_FULL - ctl.gain;
  assign att_idx = 4'(att % ATT_PER_SH);
  assign att_sh  = att / ATT_PER_SH;
  assign prod    = $signed(f_data) * $signed({1'b0, COEF[att_idx]});
  assign scaled  = $signed(prod) >>> (att_sh + 8'(COEF_FRAC));

  // Output register; mute overrides the scaler outright
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      OUT_VALID <= 1'b0;
      OUT_DATA  <= '0;
    end else if (f_ready) begin
      OUT_VALID <= f_valid;
      if (take) begin
        OUT_DATA <= (ctl.gain == '0) ? '0 : scaled[SAMPLE_W-1:0];
      end
    end
  end

  // ==========================================================
  // Peak detector on the unscaled samples
  assign mag     = f_data[SAMPLE_W-1] ? -f_data : f_data;
  assign mag_top = mag[SAMPLE_W-1 -: 16];

  // Target: top two codes share -1.5 dBFS
  assign tcode = (ctl.target > TGT_CODE_MAX) ? TGT_CODE_MAX : ctl.target;
  assign tatt  = TGT_ATT_TOP - 6'(tcode) * 6'h3;
  assign thr   = COEF[4'(tatt % 6'(ATT_PER_SH))] >> (tatt / 6'(ATT_PER_SH));

  assign over_now = ctl.on && take && (mag_top > thr);
  assign above    = peak > thr;

  // Peak holds the loudest sample since the last fall tick
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      peak <= '0;
    end else if (!ctl.on) begin
      peak <= '0;
    end else if (fall_tick) begin
      peak <= take ? mag_top : '0;
    end else if (take && mag_top > peak) begin
      peak <= mag_top;
    end
  end

  // ==========================================================
  // Step lengths: limiter style uses the faster base times
  assign fall_len = (ctl.style ? TIMER_W'(FALL_LIM) : TIMER_W'(FALL_NORM))
                    << rate_clip(ctl.fall);
  assign rise_len = (ctl.style ? TIMER_W'(RISE_LIM) : TIMER_W'(RISE_NORM))
                    << rate_clip(ctl.rise);
  assign hold_len = (ctl.hold == '0) ? '0 :
                    TIMER_W'(HOLD_BASE) << (rate_clip(ctl.hold) - 4'h1);

  assign fall_tick = ctl.on && (fall_cnt >= fall_len - 1'b1);
  assign rise_tick = (state == ST_RISE) && (rise_cnt >= rise_len - 1'b1);
  assign hold_done = hold_cnt >= hold_len;

  // Fall timer free-runs while enabled
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fall_cnt <= '0;
    end else if (!ctl.on || fall_tick) begin
      fall_cnt <= '0;
    end else begin
      fall_cnt <= fall_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Hold and rise sequencing
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state    <= ST_OFF;
      hold_cnt <= '0;
      rise_cnt <= '0;
    end else begin
      case (state)
        ST_OFF: begin
          hold_cnt <= '0;
          rise_cnt <= '0;
          if (ctl.on) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          rise_cnt <= '0;
          if (!ctl.on) begin
            state <= ST_OFF;
          end else if (over_now) begin
            hold_cnt <= '0;
          end else if (hold_done) begin
            state <= ST_RISE;
          end else begin
            hold_cnt <= hold_cnt + 1'b1;
          end
        end
        ST_RISE: begin
          hold_cnt <= '0;
          if (!ctl.on) begin
            state <= ST_OFF;
          end else if (over_now) begin
            state <= ST_HOLD;
          end else if (rise_tick) begin
            rise_cnt <= '0;
          end else begin
            rise_cnt <= rise_cnt + 1'b1;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // PGA gain: out-of-range pulls first, ceiling winning a bad pair
  assign floor_idx = {ctl.floor, FLOOR_PAD};
  assign ceil_idx  = {ctl.ceiling, CEIL_PAD};

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PGA_GAIN <= PGA_RST;
    end else if (ctl.on) begin
      if (PGA_GAIN > ceil_idx) begin
        PGA_GAIN <= PGA_GAIN - 1'b1;
      end else if (PGA_GAIN < floor_idx && PGA_GAIN < ceil_idx) begin
        PGA_GAIN <= PGA_GAIN + 1'b1;
      end else if (fall_tick && above) begin
        if (PGA_GAIN > floor_idx) begin
          PGA_GAIN <= PGA_GAIN - 1'b1;
        end
      end else if (rise_tick && !over_now && PGA_GAIN < ceil_idx) begin
        PGA_GAIN <= PGA_GAIN + 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_loud;
    ctl.on && over_now;
  endsequence

  sequence s_hold_restarted;
    (state == ST_HOLD) && (hold_cnt == '0);
  endsequence

  sequence s_in_range;
    PGA_GAIN >= floor_idx && PGA_GAIN <= ceil_idx;
  endsequence

  a_mute_output: assert property (
    take && ctl.gain == '0 |=> OUT_DATA == '0)
    else $error("muted code let a sample through");

  a_unity_gain: assert property (
    take && ctl.gain == ATT_FULL |=> OUT_DATA == $past(f_data))
    else $error("0 dB code altered the sample");

  a_half_scale: assert property (
    take && ctl.gain == 8'hF3 |=> $signed(OUT_DATA) == ($signed($past(f_data)) >>> 1))
    else $error("-6 dB code did not halve the sample");

  a_off_holds_gain: assert property (
    !ctl.on |=> $stable(PGA_GAIN))
    else $error("PGA gain moved while disabled");

  a_gain_in_range: assert property (
    ctl.on && !REG_WR && floor_idx <= ceil_idx ##0 s_in_range |=> s_in_range)
    else $error("PGA gain left the floor to ceiling range");

  a_fall_step: assert property (
    ctl.on && fall_tick && above && PGA_GAIN <= ceil_idx && PGA_GAIN > floor_idx
    |=> PGA_GAIN == $past(PGA_GAIN) - 1'b1)
    else $error("loud signal did not lower the gain by one step");

  a_rise_step: assert property (
    ctl.on && rise_tick && !over_now && PGA_GAIN >= floor_idx && PGA_GAIN < ceil_idx
    && !(fall_tick && above) |=> PGA_GAIN == $past(PGA_GAIN) + 1'b1)
    else $error("quiet signal did not raise the gain by one step");

  a_hold_restart: assert property (
    s_loud |=> s_hold_restarted)
    else $error("loud sample did not restart the hold");

  a_no_rise_in_hold: assert property (
    state == ST_HOLD && PGA_GAIN >= floor_idx |=> PGA_GAIN <= $past(PGA_GAIN))
    else $error("gain rose during hold");

  a_peak_tracks: assert property (
    ctl.on && take && !fall_tick && mag_top > peak |=> peak == $past(mag_top))
    else $error("peak detector missed a louder sample");

  a_top_target: assert property (
    ctl.target == 4'hF |-> thr == COEF[3])
    else $error("top target code is not -1.5 dBFS");

endmodule

// [hdl/level_ctl_pkg.sv]
/*
  Shared constants and types for the ADC volume and level control block:
  register addresses, field positions, reset values, step timing and the
  half-decibel coefficient table.
  Assumes a 40 MHz core clock and 16-bit full-scale samples.
*/
package level_ctl_pkg;

  // ==========================================================
  // Clock
  localparam int CLK_PERIOD_NS = 25;

  // ==========================================================
  // Register addresses (7-bit control port address)
  localparam logic [6:0] ADDR_GAIN = 7'h0F;
  localparam logic [6:0] ADDR_LC1  = 7'h20;
  localparam logic [6:0] ADDR_LC2  = 7'h21;
  localparam logic [6:0] ADDR_LC3  = 7'h22;

  // ==========================================================
  // Field positions
  localparam int ON_BIT     = 8;
  localparam int CEIL_LSB   = 3;
  localparam int FLOOR_LSB  = 0;
  localparam int HOLD_LSB   = 4;
  localparam int TARGET_LSB = 0;
  localparam int STYLE_BIT  = 8;
  localparam int RISE_LSB   = 4;
  localparam int FALL_LSB   = 0;

  // ==========================================================
  // Control state carried as one struct
  typedef struct packed {
    logic [7:0] gain;
    logic       on;
    logic [2:0] ceiling;
    logic [2:0] floor;
    logic [3:0] hold;
    logic [3:0] target;
    logic       style;
    logic [3:0] rise;
    logic [3:0] fall;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{
    gain: 8'hFF, on: 1'h0, ceiling: 3'h7, floor: 3'h0, hold: 4'h0,
    target: 4'hB, style: 1'h0, rise: 4'h3, fall: 4'h2};

  typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_RISE} lvl_state_t;

  // ==========================================================
  // PGA gain code: 0.75 dB per code, code 16 is 0 dB
  localparam int          PGA_W       = 6;
  localparam logic [5:0]  PGA_RST     = 6'h10;
  localparam logic [2:0]  FLOOR_PAD   = 3'h0;
  localparam logic [2:0]  CEIL_PAD    = 3'h7;

  // ==========================================================
  // Step and hold timing
  localparam int TIMER_W        = 32;
  localparam int FALL_NORM_NS   = 104000;
  localparam int FALL_LIM_NS    = 22700;
  localparam int RISE_NORM_NS   = 410000;
  localparam int RISE_LIM_NS    = 90800;
  localparam int HOLD_BASE_NS   = 2670000;
  localparam int FALL_NORM_CYC  = FALL_NORM_NS / CLK_PERIOD_NS;
  localparam int FALL_LIM_CYC   = FALL_LIM_NS / CLK_PERIOD_NS;
  localparam int RISE_NORM_CYC  = RISE_NORM_NS / CLK_PERIOD_NS;
  localparam int RISE_LIM_CYC   = RISE_LIM_NS / CLK_PERIOD_NS;
  localparam int HOLD_BASE_CYC  = HOLD_BASE_NS / CLK_PERIOD_NS;
  localparam logic [3:0] RATE_CODE_MAX = 4'hA;

  // ==========================================================
  // Attenuation in half-dB steps: 12 steps make one halving
  localparam logic [7:0] ATT_FULL    = 8'hFF;
  localparam logic [7:0] ATT_PER_SH  = 8'h0C;
  localparam int         COEF_FRAC   = 15;
  localparam logic [5:0] TGT_ATT_TOP = 6'h2D;
  localparam logic [3:0] TGT_CODE_MAX = 4'hE;
  localparam logic [15:0] COEF [12] = '{
    16'h8000, 16'h78D7, 16'h7215, 16'h6BB3, 16'h65AD, 16'h5FFD,
    16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};

endpackage

// [hdl/sample_fifo.sv]
/*
  Flip-flop FIFO for the sample stream, valid/ready on both sides.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Filling side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // ==========================================================
  // Flags straight from the fill count
  assign in_ready  = count != AW'(0) + (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage needs no reset, only pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// [dv/adc_side_model.sv]
/*
  Far-side model: decimator feeding samples and a sink taking them.
  Assumes the bench fills tx_q or sets amp, and reads rx_q.
*/
`timescale 1ns/1ps
module adc_side_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Sample source
  output      logic        in_valid,
  input  wire logic        in_ready,
  output      logic [15:0] in_data,
  // Sample sink
  input  wire logic        out_valid,
  output      logic        out_ready,
  input  wire logic [15:0] out_data
);
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  bit          stall;
  int          amp;
  bit          flip;
  logic        took;

  // Quiet start: nothing offered, sink stalled
  initial begin
    in_valid  = 1'b0;
    in_data   = 16'h0000;
    out_ready = 1'b0;
    stall     = 1'b0;
    amp       = 0;
    flip      = 1'b0;
  end

  // ==========================================================
  // Handshakes: sample at the edge, change just after it
  always @(posedge clk) begin
    took = in_valid && in_ready;
    if (out_valid && out_ready) rx_q.push_back(out_data);
    #1;
    // Guarded: a tone switched off in this step has nothing queued
    if (took && amp == 0 && tx_q.size() != 0) void'(tx_q.pop_front());
    if (took) flip = ~flip;
    // Random stalls so the sink is sometimes slow
    out_ready = rstn && !stall && ($urandom_range(3) != 0);
    if (amp != 0) begin
      in_valid = 1'b1;
      in_data  = flip ? amp[15:0] : -amp[15:0];
    end else if (tx_q.size() != 0) begin
      in_valid = 1'b1;
      in_data  = tx_q[0];
    end else begin
      // Released line shows no stale value
      in_valid = 1'b0;
      in_data  = ~in_data;
    end
  end
endmodule

// [dv/tb.sv]
/*
  Self-checking bench for the volume and level control block.
  Assumes shortened step timing parameters and the far-side model.
*/
`timescale 1ns/1ps
module tb;
  import level_ctl_pkg::*;
  localparam int RN = 12;
  localparam int HB = 10;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [8:0]  reg_wdata = 9'h000;
  logic [8:0]  reg_rdata;
  logic        in_valid, in_ready, out_valid, out_ready;
  logic [15:0] in_data, out_data;
  logic [5:0]  pga_gain;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [8:0]  v;
  logic [5:0]  g;
  logic [15:0] s;
  logic [15:0] exp_q[$];
  logic [7:0]  codes [7];

  always #12.5 clk = ~clk;

  level_control #(.FALL_NORM(8), .FALL_LIM(4), .RISE_NORM(RN), .RISE_LIM(6),
                  .HOLD_BASE(HB)) u_dut (
    .CLK(clk), .RSTN(rstn), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_DATA(in_data), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_DATA(out_data), .PGA_GAIN(pga_gain));

  adc_side_model u_part (
    .clk(clk), .rstn(rstn), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));

  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
    tests_run++;
    if (got !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("Run exceeded its cycle ceiling");
      print_verdict();
    end
  end

  // ==========================================================
  // Register port and expectations
  task automatic reg_write(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [6:0] a, output logic [8:0] d);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Step past the edge so registered outputs have settled
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Half-dB attenuation: fraction of a halving, then whole halvings
  function automatic logic [15:0] scaled(input logic [7:0] code, input logic [15:0] x);
    int att;
    logic signed [47:0] p;
    if (code == 8'h00) return 16'h0000;
    att = 255 - code;
    p = $signed(x) * $signed({1'b0, COEF[att % 12]});
    p = p >>> (15 + att / 12);
    return p[15:0];
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hA057));
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    reg_read(ADDR_GAIN, v);
    check("volume reset", 16'h00FF, 16'(v));
    reg_read(ADDR_LC1, v);
    check("control one reset", 16'h0038, 16'(v));
    reg_read(ADDR_LC2, v);
    check("control two reset", 16'h000B, 16'(v));
    reg_read(ADDR_LC3, v);
    check("control three reset", 16'h0032, 16'(v));
    reg_read(7'h10, v);
    check("unmapped read", 16'h0000, 16'(v));
    s = 16'($urandom);
    reg_write(ADDR_LC2, {1'b0, s[7:4], 4'hF});
    reg_read(ADDR_LC2, v);
    check("control two readback", {8'h00, s[7:4], 4'hF}, 16'(v));
    $display("Test registers done");

    // Mute, extremes and random codes; fill until refused, then drain
    codes = '{8'h00, 8'h01, 8'hFF, 8'h80, 8'hF3, 8'h00, 8'h00};
    codes[5] = 8'($urandom);
    codes[6] = 8'($urandom);
    foreach (codes[i]) begin
      reg_write(ADDR_GAIN, {1'b0, codes[i]});
      u_part.stall = 1'b1;
      for (int k = 0; k < 20; k++) begin
        s = (k == 0) ? 16'h8000 : 16'($urandom);
        u_part.tx_q.push_back(s);
        exp_q.push_back(scaled(codes[i], s));
      end
      wait_cycles(30);
      check("input ready when full", 16'h0000, 16'(in_ready));
      u_part.stall = 1'b0;
      for (int k = 0; k < 200 && u_part.rx_q.size() < 20; k++) @(posedge clk);
      while (exp_q.size() != 0) check("scaled sample", exp_q.pop_front(), u_part.rx_q.pop_front());
    end
    check("gain frozen while off", 16'h0010, 16'(pga_gain));
    $display("Test volume done");

    // Quiet input climbs to ceiling code 3, never past it; fall code 1
    reg_write(ADDR_LC3, 9'h001);
    reg_write(ADDR_LC2, 9'h000);
    reg_write(ADDR_LC1, 9'h119);
    u_part.amp = 16;
    wait_cycles(400);
    check("ceiling reached", 16'd31, 16'(pga_gain));
    wait_cycles(100);
    check("ceiling held", 16'd31, 16'(pga_gain));
    $display("Test rise done");

    // Loud input falls; quiet samples still in the FIFO delay the first step,
    // so pace is timed from it: fall code 1 is one step per 16 cycles
    u_part.amp = 32767;
    g = pga_gain;
    for (int k = 0; k < 200 && pga_gain == g; k++) wait_cycles(1);
    g = pga_gain;
    wait_cycles(64);
    check("fall pace", 16'h0001, 16'(g - pga_gain >= 3 && g - pga_gain <= 4));
    wait_cycles(320);
    check("floor reached", 16'd8, 16'(pga_gain));
    reg_write(ADDR_LC3, 9'h100);
    reg_write(ADDR_LC1, 9'h118);
    g = pga_gain;
    wait_cycles(24);
    check("limiter fall pace", 16'h0001, 16'((g - pga_gain) >= 4 && (g - pga_gain) <= 6));
    wait_cycles(100);
    check("lowest floor", 16'd0, 16'(pga_gain));
    $display("Test fall done");

    // Hold code 3 is 4*HB cycles before any rise
    reg_write(ADDR_LC3, 9'h000);
    reg_write(ADDR_LC2, 9'h030);
    u_part.amp = 0;
    for (int k = 0; k < 200 && out_valid !== 1'b0; k++) @(posedge clk);
    wait_cycles(3 * HB);
    check("held after loud", 16'd0, 16'(pga_gain));
    wait_cycles(HB + RN + 8);
    check("rise after hold", 16'h0001, 16'(pga_gain >= 1 && pga_gain <= 2));
    reg_write(ADDR_LC1, 9'h018);
    g = pga_gain;
    wait_cycles(100);
    check("frozen after disable", 16'(g), 16'(pga_gain));
    $display("Test hold done");
    print_verdict();
  end
endmodule
